// ---- verilog/smu_consts.svh ----
/*
  Constants for the serial multiprocessor and synchronous unit.
  Assumes it is included by bare name from the top module only.
*/
// What this block does
// - extra frame bit marks ID versus data
// - receiver skips frames until bit is 1
// - matching station accepts data; others skip again
// - four formats; parity ignored in multiprocessor mode
// - empty flag cleared means load shift register
// - after load set empty flag, optional interrupt
// - start, data LSB first, mp bit, stops
// - at stop bit reload or set complete
// - DMA write clears empty flag automatically
// - sync tx and rx share clock, double buffered
// - sync data changes on fall, sampled on rise
// - sync characters are eight bits, no extras
// - clock source chosen by mode and clock_source_sel_hi; clock_source_sel_lo unused
// - eight pulses per character, clock rests high
// - receive-only internal clock runs until overrun or off
// - tx off sets empty flag, rx off keeps data
// - sync bit 7 check: reload or complete, hold MSB
// - clock idle after sync transmission ends with receive off
// - leftover error flags block receive and transmit
// - overrun when full; shift data not transferred
`ifndef SMU_CONSTS_SVH
`define SMU_CONSTS_SVH
`define SMU_BIT_DIV 16
`define SMU_STAT_RST 8'hC0
`define SMU_DLEN8 4'h8
`define SMU_DLEN7 4'h7
`define SMU_SYNC_LAST 4'h7
`define SMU_MASK7 8'h7F
`define SMU_MASK8 8'hFF
`define SMU_LK_PRE 3'h6
`define SMU_LK_LAST 3'h7
`endif

// ---- verilog/smu_pkg.sv ----
/*
  Types for the serial multiprocessor and synchronous unit.
  Assumes smu_consts.svh is on the include path.
*/
package smu_pkg;
  typedef struct packed {
    logic sync_async_select;
    logic clock_source_sel_hi;
    logic clock_source_sel_lo;
    logic char_7bit;
    logic two_stop;
    logic mp_format;
    logic parity_en;
    logic parity_odd;
  } smu_cfg_t;
  typedef struct packed {
    logic tx_empty_flag;
    logic tx_complete_flag;
    logic rx_full_flag;
    logic overrun_flag;
    logic framing_fault_flag;
    logic parity_error_flag;
    logic multiproc_bit_rx;
    logic id_match;
  } smu_stat_t;
  typedef struct packed {
    logic tx_data_wr;
    logic dma_tx_wr;
    logic tx_empty_clr;
    logic rx_full_clr;
    logic overrun_clr;
    logic framing_clr;
    logic parity_clr;
  } smu_cmd_t;
  typedef enum logic [4:0] {
    TX_IDLE = 5'h01,
    TX_START = 5'h02,
    TX_DATA = 5'h04,
    TX_EXTRA = 5'h08,
    TX_STOP = 5'h10
  } smu_tx_st_t;
  typedef enum logic [2:0] {
    RX_IDLE = 3'h1,
    RX_START = 3'h2,
    RX_BITS = 3'h4
  } smu_rx_st_t;
endpackage : smu_pkg

// ---- verilog/smu_top.sv ----
/*
  Serial unit: async multiprocessor frames and clocked synchronous mode.
  Assumes ref_clk at 200 MHz; sck_link is the external serial clock,
  running only while characters are exchanged in external clock mode.
*/
`timescale 1ns/1ps
`include "smu_consts.svh"
module smu_top import smu_pkg::*; #(
  parameter int BIT_DIV = `SMU_BIT_DIV
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic sck_link,
  input wire smu_cfg_t cfg,
  input wire smu_cmd_t cmd,
  input wire logic tx_on,
  input wire logic rx_on,
  input wire logic tx_empty_irq_en,
  input wire logic tx_complete_irq_en,
  input wire logic multiproc_bit_tx,
  input wire logic [7:0] tx_data_in,
  input wire logic [7:0] station_id,
  input wire logic pin_direction_bit,
  input wire logic pin_output_level,
  input wire logic rxd,
  output smu_stat_t status,
  output logic [7:0] rx_data,
  output logic tx_empty_irq,
  output logic tx_complete_irq,
  output logic tx_line,
  output logic tx_line_oe,
  output logic tx_line_link,
  output logic sck_out,
  output logic sck_oe
);
  localparam logic [15:0] DIV_M1 = 16'(BIT_DIV - 1);
  localparam logic [15:0] HALF = 16'(BIT_DIV / 2);
  localparam logic [15:0] HALF_M1 = 16'(BIT_DIV / 2 - 1);

  // reset release and pin synchronisers
  logic [1:0] rst_pipe_reg;
  logic rxd_s1_reg, rxd_s2_reg;
  wire rst_n = rst_pipe_reg[1];
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_pipe_reg <= 2'h0;
    end else begin
      rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxd_s1_reg <= 1'b1;
      rxd_s2_reg <= 1'b1;
    end else begin
      rxd_s1_reg <= rxd;
      rxd_s2_reg <= rxd_s1_reg;
    end
  end

  smu_stat_t stat_reg, stat_next;
  smu_tx_st_t tx_st_reg, tx_st_next;
  smu_rx_st_t rx_st_reg, rx_st_next;
  logic [7:0] tdr_reg, rdr_reg, rdr_next;
  logic [8:0] tsr_reg, tsr_next;
  logic [3:0] bcnt_reg, bcnt_next, rcnt_reg, rcnt_next;
  logic [15:0] tmr_reg, tmr_next, rtmr_reg, rtmr_next;
  logic [9:0] rsh_reg, rsh_next;
  logic txd_reg, txd_next, txoe_reg, sck_reg, sckoe_reg;
  logic txi_reg, txi_next, tei_reg, tei_next;
  logic req_reg, ext_tx_en_reg, ext_rx_en_reg;
  logic ack_s1_reg, ack_s2_reg;
  logic [2:0] done_sync_reg, rtog_sync_reg;
  logic ld, fin, a_done, s_done;
  logic lk_ack_reg, lk_done_reg, lk_rtog_reg;
  logic [7:0] lk_rword_reg;

  // mode decode
  wire sync_m = cfg.sync_async_select;
  wire ext_m = sync_m & cfg.clock_source_sel_hi;
  wire int_sync = sync_m & ~cfg.clock_source_sel_hi;
  wire err_any = stat_reg.overrun_flag | stat_reg.framing_fault_flag
    | stat_reg.parity_error_flag;
  wire tx_go = tx_on & ~err_any;
  wire rx_go = rx_on & ~err_any;
  wire [3:0] dlen = (sync_m | ~cfg.char_7bit) ? `SMU_DLEN8 : `SMU_DLEN7;
  wire extra = ~sync_m & (cfg.mp_format | cfg.parity_en);
  wire [7:0] dmask = (cfg.char_7bit & ~sync_m) ? `SMU_MASK7 : `SMU_MASK8;
  wire [7:0] tdr_m = tdr_reg & dmask;
  wire tx_par = (^tdr_m) ^ cfg.parity_odd;
  wire tx_xbit = cfg.mp_format ? multiproc_bit_tx : tx_par;
  wire [8:0] tsr_load = {tx_xbit, tdr_m};
  wire rx_run = int_sync & rx_go;
  wire running = (tx_st_reg != TX_IDLE) | rx_run;
  wire tick = tmr_reg == DIV_M1;
  wire tmr_zero = tmr_reg == 16'h0000;
  wire ack_free = req_reg == ack_s2_reg;
  wire ld_ext = ext_m & tx_go & ~stat_reg.tx_empty_flag & ack_free;
  wire done_evt = done_sync_reg[2] ^ done_sync_reg[1];
  wire x_evt = rtog_sync_reg[2] ^ rtog_sync_reg[1];

  // transmitter next state
  always_comb begin
    tx_st_next = tx_st_reg;
    bcnt_next = bcnt_reg;
    tsr_next = tsr_reg;
    ld = 1'b0;
    fin = 1'b0;
    case (tx_st_reg)
      TX_IDLE: begin
        ld = tx_go & ~ext_m & ~stat_reg.tx_empty_flag & tmr_zero;
      end
      TX_START: begin
        if (tick) begin
          tx_st_next = TX_DATA;
        end
      end
      TX_DATA: begin
        if (tick && bcnt_reg == dlen - 4'h1) begin
          if (sync_m) begin
            ld = tx_go & ~stat_reg.tx_empty_flag;
            fin = ~ld;
          end else begin
            tx_st_next = extra ? TX_EXTRA : TX_STOP;
            bcnt_next = 4'h0;
          end
        end else if (tick) begin
          bcnt_next = bcnt_reg + 4'h1;
        end
      end
      TX_EXTRA: begin
        if (tick) begin
          tx_st_next = TX_STOP;
        end
      end
      TX_STOP: begin
        if (tick && cfg.two_stop && bcnt_reg == 4'h0) begin
          bcnt_next = 4'h1;
        end else if (tick) begin
          ld = tx_go & ~stat_reg.tx_empty_flag;
          fin = ~ld;
        end
      end
      default: begin
        tx_st_next = TX_IDLE;
      end
    endcase
    if (ld) begin
      tsr_next = tsr_load;
      tx_st_next = sync_m ? TX_DATA : TX_START;
      bcnt_next = 4'h0;
    end
    if (ld_ext) begin
      tsr_next = tsr_load;
    end
    if (fin) begin
      tx_st_next = TX_IDLE;
    end
    if (!tx_on) begin
      tx_st_next = TX_IDLE;
      tsr_next = 9'h000;
    end
  end

  // bit timer, line pin level and output enable
  always_comb begin
    tmr_next = (running && !tick) ? tmr_reg + 16'h0001 : 16'h0000;
    case (tx_st_reg)
      TX_START: txd_next = 1'b0;
      TX_DATA: txd_next = tsr_reg[bcnt_reg];
      TX_EXTRA: txd_next = tsr_reg[8];
      TX_STOP: txd_next = 1'b1;
      default: txd_next = sync_m ? txd_reg : 1'b1;
    endcase
    if (!tx_on) begin
      txd_next = pin_output_level;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_st_reg <= TX_IDLE;
      bcnt_reg <= 4'h0;
      tsr_reg <= 9'h000;
      tmr_reg <= 16'h0000;
      txd_reg <= 1'b1;
      txoe_reg <= 1'b0;
    end else begin
      tx_st_reg <= tx_st_next;
      bcnt_reg <= bcnt_next;
      tsr_reg <= tsr_next;
      tmr_reg <= tmr_next;
      txd_reg <= txd_next;
      txoe_reg <= tx_on | pin_direction_bit;
    end
  end

  // internal serial clock: low first half of each bit, else high
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_reg <= 1'b1;
      sckoe_reg <= 1'b0;
    end else begin
      sck_reg <= ~(int_sync & running & (tmr_reg < HALF));
      sckoe_reg <= int_sync;
    end
  end

  // receiver: async frames and internal clock sync characters
  wire rtick = int_sync ? tick : (rtmr_reg == DIV_M1);
  wire [3:0] rlast = int_sync ? `SMU_SYNC_LAST : dlen + {3'h0, extra};
  always_comb begin
    rx_st_next = rx_st_reg;
    rtmr_next = rtmr_reg + 16'h0001;
    rcnt_next = rcnt_reg;
    rsh_next = rsh_reg;
    a_done = 1'b0;
    s_done = 1'b0;
    case (rx_st_reg)
      RX_IDLE: begin
        rtmr_next = 16'h0000;
        rcnt_next = 4'h0;
        if (rx_run) begin
          rx_st_next = RX_BITS;
        end else if (rx_go && !sync_m && !rxd_s2_reg) begin
          rx_st_next = RX_START;
        end
      end
      RX_START: begin
        if (rtmr_reg == HALF_M1) begin
          rx_st_next = rxd_s2_reg ? RX_IDLE : RX_BITS;
          rtmr_next = 16'h0000;
        end
      end
      RX_BITS: begin
        if (rtick) begin
          rtmr_next = 16'h0000;
          rsh_next[rcnt_reg] = rxd_s2_reg;
          rcnt_next = rcnt_reg + 4'h1;
          if (rcnt_reg == rlast) begin
            a_done = ~int_sync;
            s_done = int_sync;
            rcnt_next = 4'h0;
            rx_st_next = int_sync ? RX_BITS : RX_IDLE;
          end
        end
      end
      default: begin
        rx_st_next = RX_IDLE;
      end
    endcase
    if (!rx_go || (sync_m && !rx_run)) begin
      rx_st_next = RX_IDLE;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_st_reg <= RX_IDLE;
      rtmr_reg <= 16'h0000;
      rcnt_reg <= 4'h0;
      rsh_reg <= 10'h000;
    end else begin
      rx_st_reg <= rx_st_next;
      rtmr_reg <= rtmr_next;
      rcnt_reg <= rcnt_next;
      rsh_reg <= rsh_next;
    end
  end

  // received character qualification
  wire [7:0] s_data = {rxd_s2_reg, rsh_reg[6:0]};
  wire [7:0] a_data = rsh_reg[7:0] & dmask;
  wire [7:0] r_data = x_evt ? lk_rword_reg : (s_done ? s_data : a_data);
  wire r_xbit = rsh_reg[dlen];
  wire dv = a_done | s_done | x_evt;
  wire mp_act = a_done & cfg.mp_format;
  wire accept = ~mp_act | r_xbit | stat_reg.id_match;
  wire take = dv & accept;
  wire fer_set = take & a_done & ~rxd_s2_reg;
  wire per_set = take & a_done & ~cfg.mp_format & cfg.parity_en
    & ((^a_data) ^ cfg.parity_odd ^ r_xbit);
  wire ovr_set = take & stat_reg.rx_full_flag;

  // status flags: a hardware set wins over a clear in the same cycle
  always_comb begin
    stat_next = stat_reg;
    rdr_next = rdr_reg;
    txi_next = 1'b0;
    tei_next = 1'b0;
    if (cmd.tx_empty_clr || cmd.dma_tx_wr) begin
      stat_next.tx_empty_flag = 1'b0;
    end
    if (ld || ld_ext) begin
      stat_next.tx_empty_flag = 1'b1;
      stat_next.tx_complete_flag = 1'b0;
      txi_next = tx_empty_irq_en;
    end
    if (fin || done_evt) begin
      stat_next.tx_complete_flag = 1'b1;
      tei_next = tx_complete_irq_en;
    end
    if (!tx_on) begin
      stat_next.tx_empty_flag = 1'b1;
    end
    stat_next.rx_full_flag = stat_reg.rx_full_flag & ~cmd.rx_full_clr;
    stat_next.overrun_flag = (stat_reg.overrun_flag & ~cmd.overrun_clr) | ovr_set;
    stat_next.framing_fault_flag = (stat_reg.framing_fault_flag & ~cmd.framing_clr)
      | fer_set;
    stat_next.parity_error_flag = (stat_reg.parity_error_flag & ~cmd.parity_clr)
      | per_set;
    if (take && !stat_reg.rx_full_flag) begin
      rdr_next = r_data;
      stat_next.multiproc_bit_rx = mp_act & r_xbit;
      stat_next.rx_full_flag = ~fer_set & ~per_set;
    end
    if (mp_act && r_xbit) begin
      stat_next.id_match = r_data == station_id;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_reg <= `SMU_STAT_RST;
      rdr_reg <= 8'h00;
      tdr_reg <= 8'h00;
      txi_reg <= 1'b0;
      tei_reg <= 1'b0;
    end else begin
      stat_reg <= stat_next;
      rdr_reg <= rdr_next;
      txi_reg <= txi_next;
      tei_reg <= tei_next;
      if (cmd.tx_data_wr || cmd.dma_tx_wr) begin
        tdr_reg <= tx_data_in;
      end
    end
  end

  // crossing to and from the external clock domain
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_reg <= 1'b0;
      ext_tx_en_reg <= 1'b0;
      ext_rx_en_reg <= 1'b0;
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
      done_sync_reg <= 3'h0;
      rtog_sync_reg <= 3'h0;
    end else begin
      req_reg <= req_reg ^ ld_ext;
      ext_tx_en_reg <= ext_m & tx_go;
      ext_rx_en_reg <= ext_m & rx_go;
      ack_s1_reg <= lk_ack_reg;
      ack_s2_reg <= ack_s1_reg;
      done_sync_reg <= {done_sync_reg[1:0], lk_done_reg};
      rtog_sync_reg <= {rtog_sync_reg[1:0], lk_rtog_reg};
    end
  end

  // link domain reset release
  logic [1:0] lk_rst_reg;
  wire lk_rst_n = lk_rst_reg[1];
  always_ff @(posedge sck_link or negedge arst_n) begin
    if (!arst_n) begin
      lk_rst_reg <= 2'h0;
    end else begin
      lk_rst_reg <= {lk_rst_reg[0], 1'b1};
    end
  end

  // link transmitter: bits change on the falling edge
  logic lk_ten_s1_reg, lk_ten_s2_reg, lk_req_s1_reg, lk_req_s2_reg;
  logic lk_busy_reg, lk_txd_reg;
  logic [7:0] lk_sh_reg;
  logic [2:0] lk_cnt_reg;
  wire lk_pend = lk_req_s2_reg ^ lk_ack_reg;
  always_ff @(negedge sck_link or negedge lk_rst_n) begin
    if (!lk_rst_n) begin
      lk_ten_s1_reg <= 1'b0;
      lk_ten_s2_reg <= 1'b0;
      lk_req_s1_reg <= 1'b0;
      lk_req_s2_reg <= 1'b0;
    end else begin
      lk_ten_s1_reg <= ext_tx_en_reg;
      lk_ten_s2_reg <= lk_ten_s1_reg;
      lk_req_s1_reg <= req_reg;
      lk_req_s2_reg <= lk_req_s1_reg;
    end
  end
  always_ff @(negedge sck_link or negedge lk_rst_n) begin
    if (!lk_rst_n) begin
      lk_busy_reg <= 1'b0;
      lk_txd_reg <= 1'b1;
      lk_sh_reg <= 8'h00;
      lk_cnt_reg <= 3'h0;
      lk_ack_reg <= 1'b0;
      lk_done_reg <= 1'b0;
    end else if (!lk_ten_s2_reg) begin
      lk_busy_reg <= 1'b0;
      lk_cnt_reg <= 3'h0;
      lk_ack_reg <= lk_req_s2_reg;
    end else if (lk_busy_reg && lk_cnt_reg != `SMU_LK_LAST) begin
      lk_sh_reg <= {1'b0, lk_sh_reg[7:1]};
      lk_txd_reg <= lk_sh_reg[1];
      lk_cnt_reg <= lk_cnt_reg + 3'h1;
      lk_done_reg <= lk_done_reg ^ ((lk_cnt_reg == `SMU_LK_PRE) & ~lk_pend);
    end else if (lk_pend) begin
      lk_sh_reg <= tsr_reg[7:0];
      lk_txd_reg <= tsr_reg[0];
      lk_ack_reg <= ~lk_ack_reg;
      lk_busy_reg <= 1'b1;
      lk_cnt_reg <= 3'h0;
    end else begin
      lk_busy_reg <= 1'b0;
    end
  end

  // link receiver: bits sampled on the rising edge
  logic lk_ren_s1_reg, lk_ren_s2_reg;
  logic [7:0] lk_rsh_reg;
  logic [2:0] lk_rcnt_reg;
  always_ff @(posedge sck_link or negedge lk_rst_n) begin
    if (!lk_rst_n) begin
      lk_ren_s1_reg <= 1'b0;
      lk_ren_s2_reg <= 1'b0;
      lk_rsh_reg <= 8'h00;
      lk_rcnt_reg <= 3'h0;
      lk_rword_reg <= 8'h00;
      lk_rtog_reg <= 1'b0;
    end else begin
      lk_ren_s1_reg <= ext_rx_en_reg;
      lk_ren_s2_reg <= lk_ren_s1_reg;
      if (!lk_ren_s2_reg) begin
        lk_rcnt_reg <= 3'h0;
      end else begin
        lk_rsh_reg <= {rxd, lk_rsh_reg[7:1]};
        lk_rcnt_reg <= lk_rcnt_reg + 3'h1;
        if (lk_rcnt_reg == `SMU_LK_LAST) begin
          lk_rword_reg <= {rxd, lk_rsh_reg[7:1]};
          lk_rtog_reg <= ~lk_rtog_reg;
        end
      end
    end
  end

  assign status = stat_reg;
  assign rx_data = rdr_reg;
  assign tx_empty_irq = txi_reg;
  assign tx_complete_irq = tei_reg;
  assign tx_line = txd_reg;
  assign tx_line_oe = txoe_reg;
  assign tx_line_link = lk_txd_reg;
  assign sck_out = sck_reg;
  assign sck_oe = sckoe_reg;
endmodule : smu_top

// ---- dv/smu_properties.sv ----
/*
  Port checker for smu_top, ref_clk domain.
  Assumes it is bound to smu_top and shares its BIT_DIV.
*/
`timescale 1ns/1ps
module smu_properties import smu_pkg::*; #(
  parameter int BIT_DIV = 8
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire smu_cfg_t cfg,
  input wire logic tx_on,
  input wire logic rx_on,
  input wire logic tx_empty_irq_en,
  input wire logic pin_direction_bit,
  input wire logic pin_output_level,
  input wire smu_stat_t status,
  input wire logic [7:0] rx_data,
  input wire logic tx_empty_irq,
  input wire logic tx_complete_irq,
  input wire logic tx_line,
  input wire logic tx_line_oe,
  input wire logic sck_out,
  input wire logic sck_oe
);
  int lo_run;
  int sck_lo;
  logic err_any;
  logic async_tx;
  assign err_any = status.overrun_flag | status.framing_fault_flag | status.parity_error_flag;
  assign async_tx = tx_on & !cfg.sync_async_select;
  // low run lengths of the line and of the clock
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      lo_run <= 0;
      sck_lo <= 0;
    end else begin
      lo_run <= (tx_line || !tx_on) ? 0 : lo_run + 1;
      sck_lo <= sck_out ? 0 : sck_lo + 1;
    end
  end
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  a_txe_irq_cause: assert property (
    tx_empty_irq |-> $rose(status.tx_empty_flag) && $past(tx_empty_irq_en))
    else $error("empty irq without load");
  a_txc_irq_cause: assert property (
    tx_complete_irq |-> $rose(status.tx_complete_flag))
    else $error("complete irq without completion");
  a_start_prompt: assert property (
    $rose(status.tx_empty_flag) && $past(status.tx_complete_flag) && async_tx && $past(tx_on)
    |-> ##[0:1] !tx_line)
    else $error("start bit late");
  a_bit_length: assert property (
    $rose(tx_line) && async_tx && $past(tx_on) |-> (lo_run % BIT_DIV) == 0)
    else $error("low run not whole bits");
  a_mark_idle: assert property (
    async_tx && $past(tx_on) && $past(status.tx_complete_flag) && status.tx_complete_flag
    |-> tx_line)
    else $error("line not marking");
  a_sck_rest: assert property (
    !sck_oe && !$past(sck_oe) |-> sck_out)
    else $error("clock not resting high");
  a_sck_half: assert property (
    $rose(sck_out) |-> sck_lo == BIT_DIV / 2)
    else $error("clock low phase wrong");
  a_sck_quiet: assert property (
    $rose(status.tx_complete_flag) && cfg.sync_async_select && !cfg.clock_source_sel_hi
    && !rx_on |-> (sck_out && $stable(tx_line))[*8])
    else $error("clock or msb moved after end");
  a_overrun_keep: assert property (
    $rose(status.overrun_flag) |-> $stable(rx_data) && status.rx_full_flag)
    else $error("overrun changed data");
  a_fault_no_full: assert property (
    $rose(status.framing_fault_flag) |-> !$rose(status.rx_full_flag))
    else $error("full set on fault");
  a_err_no_load: assert property (
    err_any && $past(err_any) && tx_on && $past(tx_on) |-> !$rose(status.tx_empty_flag))
    else $error("load while error set");
  a_txoff_empty: assert property (
    !tx_on |=> status.tx_empty_flag)
    else $error("empty flag not forced");
  a_break_level: assert property (
    $past(arst_n, 3) && !tx_on && !$past(tx_on) && pin_direction_bit
    && $past(pin_direction_bit) |-> tx_line_oe && tx_line == $past(pin_output_level))
    else $error("port level not shown");
  c_overrun: cover property ($rose(status.overrun_flag));
  c_complete: cover property ($rose(tx_complete_irq));
  c_sck_pulse: cover property ($fell(sck_out));
endmodule : smu_properties

// ---- dv/smu_peer.sv ----
/*
  Far-side station: async multiprocessor peer and clocked peer.
  Assumes BDIV ref_clk cycles per bit; tasks called from tb.
*/
`timescale 1ns/1ps
module smu_peer import smu_pkg::*; #(
  parameter int BDIV = 8
) (
  input wire logic ref_clk,
  input wire smu_cfg_t cfg,
  input wire logic tx_line,
  input wire logic tx_line_link,
  input wire logic sck_out,
  output logic rxd,
  output logic sck_link,
  output logic got_v,
  output logic [8:0] got
);
  logic [8:0] w;
  int sc = 0;
  initial begin
    rxd = 1'b1;
    sck_link = 1'b1;
    got_v = 1'b0;
    got = '0;
  end
  task automatic post(input logic [8:0] v);
    @(posedge ref_clk);
    got <= v;
    got_v <= 1'b1;
    @(posedge ref_clk);
    got_v <= 1'b0;
  endtask
  // start, data LSB first, id/data bit, stop
  task automatic send_async(input logic [8:0] f, input logic stop_ok);
    @(negedge ref_clk);
    rxd = 1'b0;
    repeat (BDIV) @(negedge ref_clk);
    for (int i = 0; i < 9; i++) begin
      rxd = f[i];
      repeat (BDIV) @(negedge ref_clk);
    end
    rxd = stop_ok;
    repeat (BDIV) @(negedge ref_clk);
    rxd = 1'b1;
    repeat (2 * BDIV) @(negedge ref_clk);
  endtask
  // clock only inside the burst; data moves on falling edges
  task automatic link_byte(input logic [7:0] d, input int n);
    // two lead-in edges let the link enables settle
    for (int i = -2; i < n; i++) begin
      sck_link = 1'b0;
      rxd = d[i & 7];
      #3;
      sck_link = 1'b1;
      w[i & 7] = tx_line_link;
      #3;
    end
    rxd = ~d[7];
    if (n == 8) post({1'b0, w[7:0]});
  endtask
  initial begin
    forever begin
      @(negedge tx_line);
      if (!cfg.sync_async_select) begin
        repeat (BDIV / 2) @(negedge ref_clk);
        w = '0;
        for (int i = 0; i < 9 - cfg.char_7bit; i++) begin
          repeat (BDIV) @(negedge ref_clk);
          w[i] = tx_line;
        end
        if (cfg.char_7bit) w = {w[7], 1'b0, w[6:0]};
        post(w);
      end
    end
  end
  always @(posedge sck_out) begin
    if (cfg.sync_async_select && !cfg.clock_source_sel_hi) begin
      w[sc] = tx_line;
      sc = sc + 1;
      if (sc == 8) begin
        sc = 0;
        post({1'b0, w[7:0]});
      end
    end
  end
endmodule : smu_peer

// ---- dv/tb.sv ----
/*
  Self-checking bench for smu_top.
  Assumes smu_properties and smu_peer are compiled first.
*/
`timescale 1ns/1ps
module tb import smu_pkg::*;;
  localparam int BD = 8;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic sck_link, rxd, tx_on, rx_on, tx_empty_irq_en, tx_complete_irq_en, multiproc_bit_tx;
  logic pin_direction_bit, pin_output_level, tx_empty_irq, tx_complete_irq;
  logic tx_line, tx_line_oe, tx_line_link, sck_out, sck_oe, got_v;
  logic [7:0] tx_data_in, station_id, rx_data, d0, d1;
  logic [8:0] got;
  smu_cfg_t cfg;
  smu_cmd_t cmd;
  smu_stat_t status;
  int err_total = 0;
  int num_checks = 0;
  int cyc = 0;
  int n_txi = 0;
  int n_tei = 0;
  logic [8:0] q_tx[$];
  logic [8:0] q_rx[$];
  logic [8:0] seen;
  logic full_d = 1'b0;
  smu_top #(.BIT_DIV(BD)) dut (.ref_clk, .arst_n, .sck_link, .cfg, .cmd, .tx_on, .rx_on,
    .tx_empty_irq_en, .tx_complete_irq_en, .multiproc_bit_tx, .tx_data_in, .station_id,
    .pin_direction_bit, .pin_output_level, .rxd, .status, .rx_data, .tx_empty_irq,
    .tx_complete_irq, .tx_line, .tx_line_oe, .tx_line_link, .sck_out, .sck_oe);
  smu_peer #(.BDIV(BD)) peer (.ref_clk, .cfg, .tx_line, .tx_line_link, .sck_out, .rxd,
    .sck_link, .got_v, .got);
  always #2.5 ref_clk = ~ref_clk;
  task automatic close_out;
    if (err_total == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out
  task automatic chk_word(input string nm, input logic [8:0] e, input logic [8:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word
  task automatic wait_bit(input int k, input logic v);
    int n;
    for (n = 0; n < 3000 && status[k] !== v; n++) @(negedge ref_clk);
    if (n == 3000) chk_word("wait", {8'h00, v}, {8'h00, status[k]});
  endtask : wait_bit
  task automatic pulse(input smu_cmd_t c);
    @(negedge ref_clk);
    cmd = c;
    @(negedge ref_clk);
    cmd = '0;
  endtask : pulse
  task automatic send(input logic [7:0] d, input logic mp, input logic dma);
    wait_bit(7, 1'b1);
    q_tx.push_back({mp & !cfg.sync_async_select, cfg.char_7bit ? {1'b0, d[6:0]} : d});
    tx_data_in = d;
    multiproc_bit_tx = mp;
    pulse({!dma, dma, 5'h00});
    if (!dma) pulse(7'h10);
  endtask : send
  task automatic rcv(input logic [8:0] f, input logic keep, input logic clr);
    if (keep) q_rx.push_back(f);
    peer.send_async(f, 1'b1);
    if (clr) pulse(7'h08);
  endtask : rcv
  // result watcher: oldest note against each result
  always @(negedge ref_clk) begin
    full_d <= status.rx_full_flag;
    seen = {status.multiproc_bit_rx & !cfg.sync_async_select, rx_data};
    if (tx_empty_irq === 1'b1) n_txi++;
    if (tx_complete_irq === 1'b1) n_tei++;
    if (status.rx_full_flag === 1'b1 && full_d === 1'b0) begin
      if (q_rx.size() > 0) chk_word("rx_data", q_rx.pop_front(), seen);
      else chk_word("rx_extra", 9'h000, 9'h1FF);
    end
    if (got_v === 1'b1) begin
      if (q_tx.size() > 0) chk_word("tx_frame", q_tx.pop_front(), got);
      else chk_word("tx_extra", 9'h000, 9'h1FF);
    end
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end
  initial begin
    cfg = '0;
    cmd = '0;
    tx_on = 1'b0;
    rx_on = 1'b0;
    tx_empty_irq_en = 1'b1;
    tx_complete_irq_en = 1'b1;
    multiproc_bit_tx = 1'b0;
    tx_data_in = 8'h00;
    station_id = 8'h00;
    pin_direction_bit = 1'b1;
    pin_output_level = 1'b1;
    void'($urandom(6));
    repeat (20) @(posedge ref_clk);
    @(negedge ref_clk);
    arst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk_word("status", 9'h0C0, {1'b0, status});
    peer.link_byte(8'h00, 4);
    for (int f = 0; f < 4; f++) begin
      cfg = '0;
      cfg.mp_format = 1'b1;
      cfg.parity_en = 1'b1;
      cfg.char_7bit = f[0];
      cfg.two_stop = f[1];
      tx_on = 1'b1;
      send(8'($urandom), 1'b1, 1'b0);
      send(8'($urandom), 1'b0, 1'b1);
      wait_bit(6, 1'b1);
      repeat (BD) @(negedge ref_clk);
      chk_word("tx_mark", 9'h001, {8'h00, tx_line});
      tx_on = 1'b0;
      @(negedge ref_clk);
    end
    cfg.char_7bit = 1'b0;
    cfg.two_stop = 1'b0;
    rx_on = 1'b1;
    station_id = 8'($urandom);
    d0 = station_id ^ 8'h5A;
    rcv({1'b0, d0}, 1'b0, 1'b1);
    rcv({1'b1, d0}, 1'b1, 1'b1);
    rcv({1'b0, station_id}, 1'b0, 1'b1);
    rcv({1'b1, station_id}, 1'b1, 1'b1);
    d0 = 8'($urandom);
    d1 = 8'($urandom);
    rcv({1'b0, d0}, 1'b1, 1'b0);
    rcv({1'b0, d1}, 1'b0, 1'b0);
    chk_word("overrun", {1'b1, d0}, {status.overrun_flag, rx_data});
    pulse(7'h0C);
    peer.send_async({1'b1, d1}, 1'b0);
    chk_word("fault", 9'h002, {7'h00, status.framing_fault_flag, status.rx_full_flag});
    tx_on = 1'b1;
    send(d1, 1'b0, 1'b1);
    repeat (2 * BD) @(negedge ref_clk);
    chk_word("tx_held", 9'h000, {8'h00, status.tx_empty_flag});
    pulse(7'h02);
    wait_bit(6, 1'b0);
    wait_bit(6, 1'b1);
    tx_on = 1'b0;
    rx_on = 1'b0;
    @(negedge ref_clk);
    cfg = '0;
    cfg.sync_async_select = 1'b1;
    tx_on = 1'b1;
    send(8'($urandom), 1'b1, 1'b0);
    d1 = 8'($urandom);
    send(d1, 1'b0, 1'b1);
    wait_bit(6, 1'b1);
    repeat (BD) @(negedge ref_clk);
    chk_word("msb_hold", {7'h00, 1'b1, d1[7]}, {7'h00, sck_out, tx_line});
    pin_output_level = 1'b0;
    @(negedge ref_clk);
    tx_on = 1'b0;
    repeat (3) @(negedge ref_clk);
    chk_word("break", 9'h002, {7'h00, tx_line_oe, tx_line});
    pin_output_level = 1'b1;
    cfg.clock_source_sel_hi = 1'b1;
    tx_on = 1'b1;
    rx_on = 1'b1;
    repeat (10) @(negedge ref_clk);
    send(8'($urandom), 1'b0, 1'b0);
    repeat (10) @(negedge ref_clk);
    d1 = 8'($urandom);
    q_rx.push_back({1'b0, d1});
    peer.link_byte(d1, 8);
    wait_bit(5, 1'b1);
    repeat (4) @(negedge ref_clk);
    chk_word("irq_count", 9'h0C7, {5'(n_txi), 4'(n_tei)});
    chk_word("pending", 9'h000, 9'(q_tx.size() + q_rx.size()));
    close_out();
  end
endmodule : tb
bind smu_top smu_properties #(.BIT_DIV(BIT_DIV)) u_props (.ref_clk, .arst_n, .cfg, .tx_on,
  .rx_on, .tx_empty_irq_en, .pin_direction_bit, .pin_output_level, .status, .rx_data,
  .tx_empty_irq, .tx_complete_irq, .tx_line, .tx_line_oe, .sck_out, .sck_oe);
